//--- logic/tel_pkg.sv
// Package for the thermal excursion time log block.
// Assumes a single 200 MHz clock and host reads by byte offset of the health log.
// Notes on behaviour
// RULE1: Count minutes in warning band
// RULE2: Warning counter zero if either threshold zero
// RULE3: Count minutes at or above critical
// RULE4: Critical counter zero if critical threshold zero
// RULE5: Report sensor one reading, two bytes
// RULE6: Report sensor two reading, two bytes
// RULE7: Report sensor three reading, two bytes
// RULE8: Sub-minute accumulation per band, remainder kept
package tel_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam longint unsigned MINUTE_S    = 60;
  localparam longint unsigned MINUTE_CYCLES =
    (MINUTE_S * 64'd1000000000000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Log byte offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_WARN_TIME = 9'h0c0;  // 195:192
  localparam logic [8:0] OFF_CRIT_TIME = 9'h0c4;  // 199:196
  localparam logic [8:0] OFF_SENSOR1   = 9'h0c8;  // 201:200
  localparam logic [8:0] OFF_SENSOR2   = 9'h0ca;  // 203:202
  localparam logic [8:0] OFF_SENSOR3   = 9'h0cc;  // 205:204

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_MINUTES  = 32'h0000_0000;
  localparam logic [35:0] RST_SUBCOUNT = 36'h0_0000_0000;
  localparam logic [15:0] THRESH_OFF   = 16'h0000;
  localparam logic [7:0]  RST_LOG_BYTE = 8'h00;

endpackage

//--- logic/tel_time_log.sv
// Warning and critical band minute counters plus sensor readings, byte readable.
// Assumes temperature and threshold inputs come from logic on mclk; sensor
// readings also on mclk. Read data is registered, one cycle after the request.
// Counters saturate at all ones; MINUTE_TICKS sets the clocks in one minute.
// Sensor fields pass straight through; their encoding is the sensor's own.
`timescale 1ns/100ps
`default_nettype none
module tel_time_log
  import tel_pkg::*;
#(
  parameter longint unsigned MINUTE_TICKS = MINUTE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        operational,
  input  wire logic [15:0] composite_temp,
  input  wire logic [15:0] warning_temp_threshold,
  input  wire logic [15:0] critical_temp_threshold,
  input  wire logic [15:0] sensor1_temp,
  input  wire logic [15:0] sensor2_temp,
  input  wire logic [15:0] sensor3_temp,
  input  wire logic        log_rd,
  input  wire logic [8:0]  log_addr,
  output logic [7:0]       log_data,
  output logic             log_valid,
  output logic [31:0]      warn_minutes,
  output logic [31:0]      crit_minutes
);

  // ----------------------------------------------------------------
  // Band decision
  // ----------------------------------------------------------------
  logic warn_off;
  logic crit_off;
  logic in_warn;
  logic in_crit;

  // Unsigned compare; how a temperature is encoded is up to its source
  function automatic logic at_or_above(input logic [15:0] temp, input logic [15:0] limit);
    at_or_above = (temp >= limit);
  endfunction

  assign crit_off = (critical_temp_threshold == THRESH_OFF);
  // A zero critical threshold leaves no upper edge, so warning stops too
  assign warn_off = (warning_temp_threshold == THRESH_OFF) || crit_off;  // RULE2
  assign in_warn  = operational && !warn_off &&
                    at_or_above(composite_temp, warning_temp_threshold) &&
                    !at_or_above(composite_temp, critical_temp_threshold);  // RULE1
  assign in_crit  = operational && !crit_off &&
                    at_or_above(composite_temp, critical_temp_threshold);  // RULE3

  // ----------------------------------------------------------------
  // Band time helpers
  // ----------------------------------------------------------------

  localparam logic [35:0] TICK_LAST = 36'(MINUTE_TICKS - 1);

  // Saturate rather than wrap: a wrapped count would read as near zero
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hffff_ffff) ? v : v + 32'h0000_0001;
  endfunction

  // True on the clock that completes a minute of band time
  function automatic logic minute_closes(input logic [35:0] sub);
    minute_closes = (sub >= TICK_LAST);
  endfunction

  // Remainder after one more clock in band
  function automatic logic [35:0] sub_after(input logic [35:0] sub);
    if (minute_closes(sub)) begin
      sub_after = RST_SUBCOUNT;
    end else begin
      sub_after = sub + 36'h0_0000_0001;
    end
  endfunction

  // ----------------------------------------------------------------
  // Warning band counter
  // ----------------------------------------------------------------

  logic [35:0] warn_sub_reg;
  logic [35:0] warn_sub_next;
  logic [31:0] warn_min_reg;
  logic [31:0] warn_min_next;

  // Remainder survives leaving the band, so short visits still add up
  always_comb begin
    warn_sub_next = warn_sub_reg;
    warn_min_next = warn_min_reg;
    if (in_warn) begin
      warn_sub_next = sub_after(warn_sub_reg);  // RULE8
      if (minute_closes(warn_sub_reg)) begin  // RULE8
        warn_min_next = sat_inc(warn_min_reg);  // RULE1
      end
    end
    // Zero thresholds clear time and remainder alike
    if (warn_off) begin
      warn_sub_next = RST_SUBCOUNT;  // RULE2
      warn_min_next = RST_MINUTES;  // RULE2
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      warn_sub_reg <= RST_SUBCOUNT;
      warn_min_reg <= RST_MINUTES;
    end else begin
      warn_sub_reg <= warn_sub_next;
      warn_min_reg <= warn_min_next;
    end
  end

  // Force zero on the visible value in the same cycle a threshold goes zero
  assign warn_minutes = warn_off ? RST_MINUTES : warn_min_reg;  // RULE2

  // ----------------------------------------------------------------
  // Critical band counter
  // ----------------------------------------------------------------

  logic [35:0] crit_sub_reg;
  logic [35:0] crit_sub_next;
  logic [31:0] crit_min_reg;
  logic [31:0] crit_min_next;

  // Only its own threshold clears it; a zero warning threshold does not
  always_comb begin
    crit_sub_next = crit_sub_reg;
    crit_min_next = crit_min_reg;
    if (in_crit) begin
      crit_sub_next = sub_after(crit_sub_reg);  // RULE8
      if (minute_closes(crit_sub_reg)) begin  // RULE8
        crit_min_next = sat_inc(crit_min_reg);  // RULE3
      end
    end
    if (crit_off) begin
      crit_sub_next = RST_SUBCOUNT;  // RULE4
      crit_min_next = RST_MINUTES;  // RULE4
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      crit_sub_reg <= RST_SUBCOUNT;
      crit_min_reg <= RST_MINUTES;
    end else begin
      crit_sub_reg <= crit_sub_next;
      crit_min_reg <= crit_min_next;
    end
  end

  assign crit_minutes = crit_off ? RST_MINUTES : crit_min_reg;  // RULE4

  // ----------------------------------------------------------------
  // Log read decode
  // ----------------------------------------------------------------

  // Byte of a two byte field; the lower offset holds the low byte
  function automatic logic [7:0] half_byte(input logic [15:0] v, input logic hi);
    half_byte = hi ? v[15:8] : v[7:0];
  endfunction

  // Byte of a four byte field; the lowest offset holds the low byte
  function automatic logic [7:0] word_byte(input logic [31:0] v, input logic [1:0] idx);
    word_byte = 8'h00;
    unique case (idx)
      2'h0: word_byte = v[7:0];
      2'h1: word_byte = v[15:8];
      2'h2: word_byte = v[23:16];
      2'h3: word_byte = v[31:24];
    endcase
  endfunction

  logic [7:0] data_next;
  logic       valid_next;

  // Unmapped offsets still answer, with a zero byte
  always_comb begin
    data_next  = RST_LOG_BYTE;
    valid_next = log_rd;
    if (log_rd) begin
      unique case (log_addr)
        OFF_WARN_TIME:         data_next = word_byte(warn_minutes, 2'h0);
        OFF_WARN_TIME + 9'h1:  data_next = word_byte(warn_minutes, 2'h1);
        OFF_WARN_TIME + 9'h2:  data_next = word_byte(warn_minutes, 2'h2);
        OFF_WARN_TIME + 9'h3:  data_next = word_byte(warn_minutes, 2'h3);
        OFF_CRIT_TIME:         data_next = word_byte(crit_minutes, 2'h0);
        OFF_CRIT_TIME + 9'h1:  data_next = word_byte(crit_minutes, 2'h1);
        OFF_CRIT_TIME + 9'h2:  data_next = word_byte(crit_minutes, 2'h2);
        OFF_CRIT_TIME + 9'h3:  data_next = word_byte(crit_minutes, 2'h3);
        OFF_SENSOR1:           data_next = half_byte(sensor1_temp, 1'b0);  // RULE5
        OFF_SENSOR1 + 9'h1:    data_next = half_byte(sensor1_temp, 1'b1);  // RULE5
        OFF_SENSOR2:           data_next = half_byte(sensor2_temp, 1'b0);  // RULE6
        OFF_SENSOR2 + 9'h1:    data_next = half_byte(sensor2_temp, 1'b1);  // RULE6
        OFF_SENSOR3:           data_next = half_byte(sensor3_temp, 1'b0);  // RULE7
        OFF_SENSOR3 + 9'h1:    data_next = half_byte(sensor3_temp, 1'b1);  // RULE7
        default:               data_next = RST_LOG_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Log read register
  // ----------------------------------------------------------------

  logic [7:0] data_reg;
  logic       valid_reg;

  // One cycle of latency keeps the read mux off the counter paths
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_reg  <= RST_LOG_BYTE;
      valid_reg <= 1'b0;
    end else begin
      data_reg  <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign log_data  = data_reg;
  assign log_valid = valid_reg;

endmodule // tel_time_log
`default_nettype wire

//--- tb/tel_time_log_props.sv
// Checker: band minute counters and log reads of tel_time_log.
// Assumes a bind to tel_time_log run with MINUTE_TICKS of 4.
`timescale 1ns/100ps
`default_nettype none
module tel_props #(parameter longint unsigned MINUTE_TICKS = 4) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        operational,
  input wire logic        log_rd,
  input wire logic        log_valid,
  input wire logic [15:0] composite_temp,
  input wire logic [15:0] warning_temp_threshold,
  input wire logic [15:0] critical_temp_threshold,
  input wire logic [15:0] sensor1_temp,
  input wire logic [15:0] sensor2_temp,
  input wire logic [15:0] sensor3_temp,
  input wire logic [8:0]  log_addr,
  input wire logic [7:0]  log_data,
  input wire logic [31:0] warn_minutes,
  input wire logic [31:0] crit_minutes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic c_on = critical_temp_threshold != 16'h0;
  wire logic w_on = c_on && warning_temp_threshold != 16'h0;
  wire logic wband = operational && w_on && composite_temp >= warning_temp_threshold
    && composite_temp < critical_temp_threshold;
  wire logic cband = operational && c_on && composite_temp >= critical_temp_threshold;
  function automatic logic [7:0] pick(logic hi, logic [15:0] v);
    return hi ? v[15:8] : v[7:0];
  endfunction
  property p_w_inc; warn_minutes != $past(warn_minutes) && warn_minutes != 32'h0
    |-> $past(wband) && warn_minutes == $past(warn_minutes) + 32'h1; endproperty
  a_w_inc: assert property (p_w_inc) else $error("warn count step");
  property p_w_zero; !w_on |-> warn_minutes == 32'h0; endproperty
  a_w_zero: assert property (p_w_zero) else $error("warn count not zero");
  property p_c_inc; crit_minutes != $past(crit_minutes) && crit_minutes != 32'h0
    |-> $past(cband) && crit_minutes == $past(crit_minutes) + 32'h1; endproperty
  a_c_inc: assert property (p_c_inc) else $error("crit count step");
  property p_c_zero; !c_on |-> crit_minutes == 32'h0; endproperty
  a_c_zero: assert property (p_c_zero) else $error("crit count not zero");
  property p_s1; log_rd && log_addr[8:1] == 8'h64
    |=> log_valid && log_data == pick($past(log_addr[0]), $past(sensor1_temp)); endproperty
  a_s1: assert property (p_s1) else $error("sensor one byte");
  property p_s2; log_rd && log_addr[8:1] == 8'h65
    |=> log_valid && log_data == pick($past(log_addr[0]), $past(sensor2_temp)); endproperty
  a_s2: assert property (p_s2) else $error("sensor two byte");
  property p_s3; log_rd && log_addr[8:1] == 8'h66
    |=> log_valid && log_data == pick($past(log_addr[0]), $past(sensor3_temp)); endproperty
  a_s3: assert property (p_s3) else $error("sensor three byte");
  // Three quiet edges fit a minute of four ticks or more
  property p_rem; warn_minutes != $past(warn_minutes) && warn_minutes != 32'h0
    |=> (warn_minutes == 32'h0 || $stable(warn_minutes)) [*3]; endproperty
  a_rem: assert property (p_rem) else $error("minute too short");
  c_warn: cover property (warn_minutes == 32'h2);
  c_crit: cover property (crit_minutes == 32'h2);
  c_read: cover property (log_rd ##1 log_rd);
endmodule // tel_props
bind tel_time_log tel_props #(.MINUTE_TICKS(MINUTE_TICKS)) u_props (.mclk, .rst_n, .operational,
  .log_rd, .log_valid, .composite_temp, .warning_temp_threshold, .critical_temp_threshold,
  .sensor1_temp, .sensor2_temp, .sensor3_temp, .log_addr, .log_data, .warn_minutes,
  .crit_minutes);
`default_nettype wire

//--- tb/tel_host_model.sv
// Host reader of the health log, back to back byte requests.
// Assumes callers enter rd at a falling edge of mclk.
`timescale 1ns/100ps
`default_nettype none
module tel_host_model (
  input  wire logic       mclk,
  input  wire logic       log_valid,
  input  wire logic [7:0] log_data,
  output logic            log_rd,
  output logic [8:0]      log_addr
);
  initial begin
    log_rd = 1'b0;
    log_addr = 9'h0;
  end
  task automatic rd(input logic [8:0] a, input int n, output logic [31:0] d, output logic ok);
    ok = 1'b1;
    d = 32'h0;
    log_rd = 1'b1;
    for (int i = 0; i < n; i++) begin
      log_addr = a + 9'(i);
      @(negedge mclk);
      ok &= log_valid;
      d[8*i +: 8] = log_data;
    end
    log_rd = 1'b0;
    // Released address must not look like a live one
    log_addr = ~log_addr;
    // An edge passes so a following call never re-raises log_rd in this step
    @(negedge mclk);
  endtask
endmodule // tel_host_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for tel_time_log with a host reader.
// Assumes MINUTE_TICKS of 4, so a minute is four in-band clocks.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk, rst_n, operational, log_rd, log_valid, ok;
  logic [15:0] composite_temp, warning_temp_threshold, critical_temp_threshold, sens [3];
  logic [8:0]  log_addr;
  logic [7:0]  log_data;
  logic [31:0] warn_minutes, crit_minutes, d;
  int          num_errors, n_checks;
  tel_time_log #(.MINUTE_TICKS(4)) uut (.mclk, .rst_n, .operational, .composite_temp,
    .warning_temp_threshold, .critical_temp_threshold, .sensor1_temp(sens[0]),
    .sensor2_temp(sens[1]), .sensor3_temp(sens[2]), .log_rd, .log_addr, .log_data,
    .log_valid, .warn_minutes, .crit_minutes);
  tel_host_model host (.mclk, .log_valid, .log_data, .log_rd, .log_addr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [15:0] t, input logic op, input int n);
    composite_temp = t;
    operational = op;
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [31:0] mins(input int ticks);
    return 32'(ticks / 4);
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    sens = '{16'h0, 16'h0, 16'h0};
    warning_temp_threshold = 16'h0;
    critical_temp_threshold = 16'h0;
    run(16'h0, 1'b0, 12);
    rst_n = 1'b1;
    void'($urandom(32'h8c5e));
    for (int i = 0; i < 3; i++) begin
      sens[i] = 16'($urandom);
      host.rd(9'h0c8 + 9'(2 * i), 2, d, ok);
      chk(32'({ok, d[15:0]}), 32'({1'b1, sens[i]}));
    end
    host.rd(9'h0ce, 2, d, ok);
    chk(32'({ok, d[15:0]}), 32'h10000);
    $display("test sensors done");
    warning_temp_threshold = 16'(40 + $urandom_range(50));
    critical_temp_threshold = warning_temp_threshold + 16'(1 + $urandom_range(50));
    run(warning_temp_threshold, 1'b1, 6);
    run(16'h0, 1'b1, 3);
    run(critical_temp_threshold - 16'h1, 1'b1, 2);
    chk(warn_minutes, mins(8));
    run(critical_temp_threshold, 1'b0, 8);
    chk(crit_minutes, 32'h0);
    run(critical_temp_threshold, 1'b1, 5);
    run(16'hffff, 1'b1, 3);
    chk(crit_minutes, mins(8));
    run(16'h0, 1'b0, 1);
    host.rd(9'h0c0, 4, d, ok);
    chk(d, mins(8));
    host.rd(9'h0c4, 4, d, ok);
    chk(d, mins(8));
    rst_n = 1'b0;
    run(16'hffff, 1'b1, 2);
    chk(warn_minutes, 32'h0);
    chk(crit_minutes, 32'h0);
    rst_n = 1'b1;
    $display("test bands done");
    d = 32'(critical_temp_threshold);
    critical_temp_threshold = 16'h0;
    run(16'hffff, 1'b1, 1);
    chk(warn_minutes, 32'h0);
    chk(crit_minutes, 32'h0);
    critical_temp_threshold = d[15:0];
    run(critical_temp_threshold, 1'b1, 4);
    chk(crit_minutes, mins(4));
    run(critical_temp_threshold - 16'h1, 1'b1, 4);
    chk(warn_minutes, mins(4));
    warning_temp_threshold = 16'h0;
    run(critical_temp_threshold - 16'h1, 1'b1, 4);
    chk(warn_minutes, 32'h0);
    chk(crit_minutes, mins(4));
    $display("test zero thresholds done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
